// File: inc/psr_pkg.sv
// constants for the processor status register bank
// Function
// R1: tile control bits 25:18 hold media transmit data delay in clock cycles, reset 0
// R2: transmit clock rises when counter equals bits 17:9, falls at half of it
// R3: tile control bit 8 enables the media interface peripheral ports, reset 0
// R4: tile control bit 4 enables the low-power clock divider; bits 4,5 reset 0
// R5: dynamic mode (bit 5) divides only while all active threads pause
// R6: bit 2 selects UTMI (1) or ULPI (0); bit 1 enables ULPI support
// R7: boot status is read-only and reports processor number in bits 23:16
// R8: boot status flags: bits 8,5,4,3,2 and boot PLL mode in 1:0
// R9: once security bit 31 is set, further writes to it are refused
// R10: security bit 12 locks all OTP sectors, bits 11:8 lock one each
// R11: security bits 14, 4 and 0 block debug and JTAG access paths
// R12: security bit 5 forces boot from OTP; bit 7 enables OTP redundancy
// R13: security register loads the security word read from OTP
// R14: four oscillators clock own counters; bit 1 core, bit 0 peripheral
// R15: software reads a counter only after its oscillator stopped 10 cycles
// R16: registers 0x07..0x0A give 16-bit counts: tile cell, wire, periph cell, wire
// R17: system reset leaves oscillator counter values unchanged
// R18: oscillators run asynchronous to the tile clock as random bit source
// R19: RAM size register reports bytes in bits 31:2, bits 1:0 reserved
// R20: debug status copy holds thread status flags at debugger entry
// R21: bit 10 address space, bit 9 entry issue mode, bit 8 current issue mode
// R22: software forms resource id as register number shifted by 8 OR 0x0B
// R23: reserved bits read zero; writes to them or read-only fields ignored
package psr_pkg;
  localparam logic [7:0] REG_TILE_CTRL = 8'h02;
  localparam logic [7:0] REG_BOOT_STAT = 8'h03;
  localparam logic [7:0] REG_SEC_CFG = 8'h05;
  localparam logic [7:0] REG_OSC_CTRL = 8'h06;
  localparam logic [7:0] REG_OSC_CNT0 = 8'h07;
  localparam logic [7:0] REG_OSC_CNT3 = 8'h0A;
  localparam logic [7:0] REG_RAM_SIZE = 8'h0C;
  localparam logic [7:0] REG_DBG_SSR = 8'h10;
  localparam logic [7:0] RES_ID_TAG = 8'h0B;
  // tile control fields
  localparam int CTL_DLY_LSB = 18;
  localparam int CTL_DIV_LSB = 9;
  localparam int CTL_RGMII_EN = 8;
  localparam int CTL_LP_DYN = 5;
  localparam int CTL_LP_EN = 4;
  localparam int CTL_UTMI_SEL = 2;
  localparam int CTL_ULPI_EN = 1;
  localparam logic [31:0] CTL_WMASK = 32'h03FF_FF36;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  // security fields
  localparam int SEC_WLOCK = 31;
  localparam int SEC_NO_GDBG = 14;
  localparam int SEC_LOCK_ALL = 12;
  localparam int SEC_LOCK_LSB = 8;
  localparam int SEC_REDUND = 7;
  localparam int SEC_OTP_BOOT = 5;
  localparam int SEC_NO_JCFG = 4;
  localparam int SEC_NO_JTAP = 0;
  localparam logic [31:0] SEC_WMASK = 32'h8000_5FB1;
  localparam logic [31:0] SEC_RESET = 32'h0000_0000;
  // oscillator control
  localparam int OSC_CORE_EN = 1;
  localparam int OSC_PERI_EN = 0;
  // debug status copy and RAM size
  localparam int SSR_DUAL_ISSUE = 8;
  localparam logic [10:0] SSR_WMASK = 11'h6DF;
  localparam logic [10:0] SSR_RESET = 11'h000;
  localparam logic [31:0] RAM_SIZE_BYTES = 32'h0001_0000;
endpackage : psr_pkg

// File: verilog/psr_regs.sv
// processor status register bank of one tile
`timescale 1ns/10ps
`default_nettype none
module psr_regs #(
  parameter logic [31:0] RAM_BYTES = psr_pkg::RAM_SIZE_BYTES,
  parameter int CNT_W = 16
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEn,
  // status access port of the core
  input wire logic [7:0] psRegNum,
  input wire logic psWrite,
  input wire logic psRead,
  input wire logic [31:0] psWdata,
  output logic [31:0] psRdata,
  output logic psRdValid,
  // tile control outputs, plus the allThreadsPaused input
  output logic [7:0] txDataDelay,
  output logic txClk,
  output logic rgmiiEnable,
  input wire logic allThreadsPaused,
  output logic lpDivActive,
  output logic utmiSelect,
  output logic ulpiEnable,
  // boot straps, from pins
  input wire logic [7:0] procNumPin,
  input wire logic bootOverwritePin,
  input wire logic core1OffPin,
  input wire logic skipOtpPollPin,
  input wire logic bootRamPin,
  input wire logic bootJtagPin,
  input wire logic [1:0] bootPllModePin,
  // security
  input wire logic otpSecLoad,
  input wire logic [31:0] otpSecWord,
  output logic secGlobalDebugOff,
  output logic secLockAllOtp,
  output logic [3:0] secLockSector,
  output logic secOtpRedundancy,
  output logic secBootFromOtp,
  output logic secJtagCfgOff,
  output logic secJtagTapOff,
  // ring oscillators, free running and asynchronous
  input wire logic [3:0] oscTick,
  output logic coreOscEnable,
  output logic periphOscEnable,
  // debug
  input wire logic debugMode,
  input wire logic debugEntry,
  input wire logic [10:0] threadStatus,
  input wire logic curDualIssue
);

  logic [31:0] ctrl_q;
  logic [31:0] sec_q;
  logic [1:0] oscCtl_q;
  logic [10:0] ssr_q;
  logic [8:0] divCnt_q;
  logic txClk_q;
  logic [31:0] rdata_q;
  logic rdValid_q;
  logic [13:0] bootSync1_q;
  logic [13:0] bootSync2_q;
  logic [3:0] oscSync1_q;
  logic [3:0] oscSync2_q;
  logic [3:0] oscLast_q;
  // power-up value only; a system reset leaves the counts alone
  logic [CNT_W-1:0] oscCnt_q [4] = '{default: '0};
  logic [8:0] divVal;
  logic [3:0] oscRun;
  logic wrCtrl;
  logic wrSec;
  logic wrOsc;
  logic wrSsr;

  // write masking keeps reserved and read-only bits untouched
  function automatic logic [31:0] mergeBits(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [31:0] mask
  );
    mergeBits = (oldVal & ~mask) | (newVal & mask);
  endfunction : mergeBits

  // the core hands over the bare register number; resource tag stripped
  assign wrCtrl = clkEn && psWrite && psRegNum == psr_pkg::REG_TILE_CTRL;
  assign wrSec = clkEn && psWrite && psRegNum == psr_pkg::REG_SEC_CFG;
  assign wrOsc = clkEn && psWrite && psRegNum == psr_pkg::REG_OSC_CTRL;
  // debug copy writable only from debug mode
  assign wrSsr = clkEn && psWrite && debugMode &&
                 psRegNum == psr_pkg::REG_DBG_SSR;

  // tile control
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= psr_pkg::CTL_RESET; // [R1] [R3] [R4]
    end else if (wrCtrl) begin
      ctrl_q <= mergeBits(ctrl_q, psWdata, psr_pkg::CTL_WMASK); // [R23]
    end
  end

  assign txDataDelay = ctrl_q[psr_pkg::CTL_DLY_LSB +: 8]; // [R1]
  assign divVal = ctrl_q[psr_pkg::CTL_DIV_LSB +: 9];
  assign rgmiiEnable = ctrl_q[psr_pkg::CTL_RGMII_EN]; // [R3]
  assign utmiSelect = ctrl_q[psr_pkg::CTL_UTMI_SEL]; // [R6]
  assign ulpiEnable = ctrl_q[psr_pkg::CTL_ULPI_EN]; // [R6]
  // static mode divides always, dynamic only while everything sleeps
  assign lpDivActive = ctrl_q[psr_pkg::CTL_LP_EN] && // [R4]
    (!ctrl_q[psr_pkg::CTL_LP_DYN] || allThreadsPaused); // [R5]

  // transmit clock divider, counter wraps at the programmed value
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      divCnt_q <= 9'h000;
    end else if (clkEn) begin
      if (divCnt_q >= divVal) begin
        divCnt_q <= 9'h000;
      end else begin
        divCnt_q <= divCnt_q + 9'h001;
      end
    end
  end

  // rise wins when value and half value coincide (divide by one)
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      txClk_q <= 1'b0;
    end else if (clkEn) begin
      if (divCnt_q == divVal) begin
        txClk_q <= 1'b1; // [R2]
      end else if (divCnt_q == (divVal >> 1)) begin
        txClk_q <= 1'b0; // [R2]
      end
    end
  end

  assign txClk = txClk_q;

  // boot straps are pin levels, two stages before use
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bootSync1_q <= 14'h0000;
      bootSync2_q <= 14'h0000;
    end else if (clkEn) begin
      bootSync1_q <= {procNumPin, bootOverwritePin, core1OffPin,
                      skipOtpPollPin, bootRamPin, bootJtagPin,
                      bootPllModePin[1]};
      bootSync2_q <= bootSync1_q;
    end
  end

  // pll mode bit 0 is folded in separately to keep the vector short
  logic [1:0] pll0Sync_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pll0Sync_q <= 2'b00;
    end else if (clkEn) begin
      pll0Sync_q <= {pll0Sync_q[0], bootPllModePin[0]};
    end
  end

  // security configuration; an OTP load always lands, lock or not
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sec_q <= psr_pkg::SEC_RESET;
    end else if (clkEn && otpSecLoad) begin
      sec_q <= otpSecWord & psr_pkg::SEC_WMASK; // [R13]
    end else if (wrSec && !sec_q[psr_pkg::SEC_WLOCK]) begin // [R9]
      sec_q <= mergeBits(sec_q, psWdata, psr_pkg::SEC_WMASK);
    end
  end

  assign secGlobalDebugOff = sec_q[psr_pkg::SEC_NO_GDBG]; // [R11]
  assign secLockAllOtp = sec_q[psr_pkg::SEC_LOCK_ALL]; // [R10]
  // the global lock also covers each sector individually
  assign secLockSector = sec_q[psr_pkg::SEC_LOCK_LSB +: 4] |
                         {4{sec_q[psr_pkg::SEC_LOCK_ALL]}}; // [R10]
  assign secOtpRedundancy = sec_q[psr_pkg::SEC_REDUND]; // [R12]
  assign secBootFromOtp = sec_q[psr_pkg::SEC_OTP_BOOT]; // [R12]
  assign secJtagCfgOff = sec_q[psr_pkg::SEC_NO_JCFG]; // [R11]
  assign secJtagTapOff = sec_q[psr_pkg::SEC_NO_JTAP]; // [R11]

  // ring oscillator control
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      oscCtl_q <= 2'b00; // [R14]
    end else if (wrOsc) begin
      oscCtl_q <= {psWdata[psr_pkg::OSC_CORE_EN],
                   psWdata[psr_pkg::OSC_PERI_EN]};
    end
  end

  assign coreOscEnable = oscCtl_q[1]; // [R14]
  assign periphOscEnable = oscCtl_q[0]; // [R14]
  // counters 0,1 belong to the tile, 2,3 to the peripheral
  assign oscRun = {{2{oscCtl_q[0]}}, {2{oscCtl_q[1]}}};

  // oscillator ticks come from free-running async rings
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      oscSync1_q <= 4'h0;
      oscSync2_q <= 4'h0;
      oscLast_q <= 4'h0;
    end else if (clkEn) begin
      oscSync1_q <= oscTick; // [R18]
      oscSync2_q <= oscSync1_q;
      oscLast_q <= oscSync2_q;
    end
  end

  // no reset: counts survive a system reset and seed randomness;
  // ring rate is limited to below half the tile clock by sampling
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 4; i++) begin
      if (clkEn && oscRun[i] && oscSync2_q[i] && !oscLast_q[i]) begin
        oscCnt_q[i] <= oscCnt_q[i] + 1'b1; // [R14] [R17]
      end
    end
  end

  // debug copy of thread status, capture beats a debugger write
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ssr_q <= psr_pkg::SSR_RESET;
    end else if (clkEn && debugEntry) begin
      ssr_q <= threadStatus & psr_pkg::SSR_WMASK; // [R20]
    end else if (wrSsr) begin
      ssr_q <= (ssr_q & ~psr_pkg::SSR_WMASK) |
               (psWdata[10:0] & psr_pkg::SSR_WMASK); // [R21]
    end
  end

  // read path, data registered one cycle after the strobe
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 32'h0000_0000;
      rdValid_q <= 1'b0;
    end else if (clkEn) begin
      rdValid_q <= psRead;
      if (psRead) begin
        rdata_q <= 32'h0000_0000; // [R23]
        unique case (psRegNum)
          psr_pkg::REG_TILE_CTRL: rdata_q <= ctrl_q;
          psr_pkg::REG_BOOT_STAT: begin
            rdata_q[23:16] <= bootSync2_q[13:6]; // [R7]
            rdata_q[8] <= bootSync2_q[5]; // [R8]
            rdata_q[5:2] <= bootSync2_q[4:1]; // [R8]
            rdata_q[1:0] <= {bootSync2_q[0], pll0Sync_q[1]}; // [R8]
          end
          psr_pkg::REG_SEC_CFG: rdata_q <= sec_q;
          psr_pkg::REG_OSC_CTRL: rdata_q[1:0] <= oscCtl_q;
          8'h07, 8'h08, 8'h09, 8'h0A: begin
            rdata_q[CNT_W-1:0] <=
              oscCnt_q[2'(psRegNum - psr_pkg::REG_OSC_CNT0)]; // [R16]
          end
          psr_pkg::REG_RAM_SIZE: begin
            rdata_q[31:2] <= RAM_BYTES[31:2]; // [R19]
          end
          psr_pkg::REG_DBG_SSR: begin
            rdata_q[10:0] <= ssr_q;
            rdata_q[psr_pkg::SSR_DUAL_ISSUE] <= curDualIssue; // [R21]
          end
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign psRdata = rdata_q;
  assign psRdValid = rdValid_q;

  // ---------------- assertions ----------------
  property p_ctrl_delay;
    @(posedge clk_sys) disable iff (!reset_n)
    wrCtrl |=> txDataDelay == $past(psWdata[25:18]);
  endproperty
  a_ctrl_delay: assert property (p_ctrl_delay) // [R1]
    else $error("transmit delay not taken from write");

  property p_tx_rise;
    @(posedge clk_sys) disable iff (!reset_n)
    clkEn && divCnt_q == divVal && !wrCtrl |=> txClk && divCnt_q == 9'h000;
  endproperty
  a_tx_rise: assert property (p_tx_rise) // [R2]
    else $error("transmit clock did not rise at divider value");

  property p_tx_fall;
    @(posedge clk_sys) disable iff (!reset_n)
    clkEn && divVal != 9'h000 && divCnt_q == (divVal >> 1) |=> !txClk;
  endproperty
  a_tx_fall: assert property (p_tx_fall) // [R2]
    else $error("transmit clock did not fall at half value");

  property p_lp_dyn;
    @(posedge clk_sys) disable iff (!reset_n)
    ctrl_q[psr_pkg::CTL_LP_DYN] && !allThreadsPaused |-> !lpDivActive;
  endproperty
  a_lp_dyn: assert property (p_lp_dyn) // [R5]
    else $error("dynamic divider active while a thread runs");

  property p_sec_lock;
    @(posedge clk_sys) disable iff (!reset_n)
    sec_q[31] && wrSec && !otpSecLoad |=> $stable(sec_q);
  endproperty
  a_sec_lock: assert property (p_sec_lock) // [R9]
    else $error("locked security register was written");

  property p_sec_load;
    @(posedge clk_sys) disable iff (!reset_n)
    clkEn && otpSecLoad |=> sec_q == ($past(otpSecWord) & 32'h8000_5FB1);
  endproperty
  a_sec_load: assert property (p_sec_load) // [R13]
    else $error("security word not loaded from OTP");

  property p_osc_stop;
    @(posedge clk_sys) disable iff (!reset_n)
    !oscCtl_q[1] ##1 !oscCtl_q[1] |-> $stable(oscCnt_q[0]);
  endproperty
  a_osc_stop: assert property (p_osc_stop) // [R14]
    else $error("stopped oscillator counter moved");

  property p_ssr_cap;
    @(posedge clk_sys) disable iff (!reset_n)
    clkEn && debugEntry |=> ssr_q == ($past(threadStatus) & 11'h6DF);
  endproperty
  a_ssr_cap: assert property (p_ssr_cap) // [R20]
    else $error("thread status not captured on debug entry");

  property p_rsvd_zero;
    @(posedge clk_sys) disable iff (!reset_n)
    clkEn && psRead && psRegNum == psr_pkg::REG_TILE_CTRL
      |=> psRdValid && psRdata[31:26] == 6'h00 && psRdata[0] == 1'b0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) // [R23]
    else $error("reserved control bits read non-zero");

  property p_boot_num;
    @(posedge clk_sys) disable iff (!reset_n)
    clkEn && psRead && psRegNum == psr_pkg::REG_BOOT_STAT
      |=> psRdata[23:16] == $past(bootSync2_q[13:6]);
  endproperty
  a_boot_num: assert property (p_boot_num) // [R7]
    else $error("boot status processor number wrong");

  property p_ctrl_rgmii;
    @(posedge clk_sys) disable iff (!reset_n)
    wrCtrl |=> rgmiiEnable == $past(psWdata[psr_pkg::CTL_RGMII_EN]);
  endproperty
  a_ctrl_rgmii: assert property (p_ctrl_rgmii) // [R3]
    else $error("media port enable not taken from write");

  property p_lp_static;
    @(posedge clk_sys) disable iff (!reset_n)
    ctrl_q[psr_pkg::CTL_LP_EN] && !ctrl_q[psr_pkg::CTL_LP_DYN]
      |-> lpDivActive;
  endproperty
  a_lp_static: assert property (p_lp_static) // [R5]
    else $error("static divider not active");

  property p_sec_sector;
    @(posedge clk_sys) disable iff (!reset_n)
    secLockAllOtp |-> secLockSector == 4'hF;
  endproperty
  a_sec_sector: assert property (p_sec_sector) // [R10]
    else $error("global lock left a sector open");

  property p_ssr_di;
    @(posedge clk_sys) disable iff (!reset_n)
    clkEn && psRead && psRegNum == psr_pkg::REG_DBG_SSR
      |=> psRdata[psr_pkg::SSR_DUAL_ISSUE] == $past(curDualIssue);
  endproperty
  a_ssr_di: assert property (p_ssr_di) // [R21]
    else $error("current issue mode not reported");

  property p_osc_peri;
    @(posedge clk_sys) disable iff (!reset_n)
    !oscCtl_q[0] |=> $stable(oscCnt_q[2]) && $stable(oscCnt_q[3]);
  endproperty
  a_osc_peri: assert property (p_osc_peri) // [R14]
    else $error("stopped peripheral counter moved");

endmodule : psr_regs
`default_nettype wire

// File: tb/test_processor_status_regs.sv
// self-checking bench for the processor status register bank
`timescale 1ns/10ps
`default_nettype none
module test_processor_status_regs;
  localparam logic [31:0] ctlMask = 32'h03FF_FF36;
  logic clk_sys, reset_n, clkEn, psWrite, psRead, allThreadsPaused;
  logic otpSecLoad, debugMode, debugEntry, curDualIssue;
  logic bootOverwritePin, core1OffPin, skipOtpPollPin, bootRamPin;
  logic bootJtagPin, psRdValid, txClk, rgmiiEnable, lpDivActive;
  logic utmiSelect, ulpiEnable, secGlobalDebugOff, secLockAllOtp;
  logic secOtpRedundancy, secBootFromOtp, secJtagCfgOff, secJtagTapOff;
  logic coreOscEnable, periphOscEnable;
  logic [7:0] psRegNum, procNumPin, txDataDelay;
  logic [31:0] psWdata, otpSecWord, psRdata, rd, v, w;
  logic [1:0] bootPllModePin;
  logic [3:0] oscTick, secLockSector;
  logic [10:0] threadStatus;
  logic [31:0] a [4];
  logic [31:0] b [4];
  logic [7:0] unmapped [5] = '{8'h04, 8'h0B, 8'h0D, 8'h11, 8'hFF};
  int err_total, checked, cycles, h, n;
  integer seed = 32'hC7598D99;

  psr_regs dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .clkEn(clkEn),
    .psRegNum(psRegNum), .psWrite(psWrite), .psRead(psRead),
    .psWdata(psWdata), .psRdata(psRdata), .psRdValid(psRdValid),
    .txDataDelay(txDataDelay), .txClk(txClk), .rgmiiEnable(rgmiiEnable),
    .allThreadsPaused(allThreadsPaused), .lpDivActive(lpDivActive),
    .utmiSelect(utmiSelect), .ulpiEnable(ulpiEnable),
    .procNumPin(procNumPin), .bootOverwritePin(bootOverwritePin),
    .core1OffPin(core1OffPin), .skipOtpPollPin(skipOtpPollPin),
    .bootRamPin(bootRamPin), .bootJtagPin(bootJtagPin),
    .bootPllModePin(bootPllModePin), .otpSecLoad(otpSecLoad),
    .otpSecWord(otpSecWord), .secGlobalDebugOff(secGlobalDebugOff),
    .secLockAllOtp(secLockAllOtp), .secLockSector(secLockSector),
    .secOtpRedundancy(secOtpRedundancy), .secBootFromOtp(secBootFromOtp),
    .secJtagCfgOff(secJtagCfgOff), .secJtagTapOff(secJtagTapOff),
    .oscTick(oscTick), .coreOscEnable(coreOscEnable),
    .periphOscEnable(periphOscEnable), .debugMode(debugMode),
    .debugEntry(debugEntry), .threadStatus(threadStatus),
    .curDualIssue(curDualIssue));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task final_report;
    if (err_total == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      err_total = err_total + 1;
      final_report;
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked = checked + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task wr(input logic [7:0] r, input logic [31:0] d);
    @(posedge clk_sys);
    psWrite <= 1'b1;
    psRegNum <= r;
    psWdata <= d;
    @(posedge clk_sys);
    psWrite <= 1'b0;
  endtask : wr

  task rdr(input logic [7:0] r);
    @(posedge clk_sys);
    psRead <= 1'b1;
    psRegNum <= r;
    @(posedge clk_sys);
    psRead <= 1'b0;
    #1;
    chk("psRdValid", 32'h1, {31'h0, psRdValid});
    rd = psRdata;
  endtask : rdr

  // four fields of each rising edge held two cycles, so the synchroniser sees it
  task tick(input int cnt);
    repeat (cnt) begin
      @(posedge clk_sys);
      oscTick <= 4'hF;
      repeat (2) @(posedge clk_sys);
      oscTick <= 4'h0;
      repeat (2) @(posedge clk_sys);
    end
  endtask : tick

  task readOsc(output logic [31:0] q [4]);
    for (int i = 0; i < 4; i++) begin
      rdr(8'h07 + 8'(i));
      q[i] = rd;
      chk("oscReserved", 32'h0, {rd[31:16], 16'h0});
    end
  endtask : readOsc

  function automatic logic [31:0] secOut();
    return {secJtagTapOff, secJtagCfgOff, secBootFromOtp, secOtpRedundancy,
      secLockSector, secLockAllOtp, secGlobalDebugOff, 22'h0};
  endfunction : secOut

  function automatic logic [31:0] secExp(input logic [31:0] s);
    return {s[0], s[4], s[5], s[7], s[11:8] | {4{s[12]}}, s[12], s[14],
      22'h0};
  endfunction : secExp

  function automatic logic [31:0] bootExp();
    return {8'h0, procNumPin, 7'h0, bootOverwritePin, 2'b00, core1OffPin,
      skipOtpPollPin, bootRamPin, bootJtagPin, bootPllModePin};
  endfunction : bootExp

  function automatic logic [31:0] ssrExp(input logic [31:0] s);
    return (s & 32'h6DF) | {23'h0, curDualIssue, 8'h0};
  endfunction : ssrExp

  initial begin
    reset_n = 0; clkEn = 1; psWrite = 0; psRead = 0; psRegNum = 0;
    psWdata = 0; allThreadsPaused = 0; otpSecLoad = 0; otpSecWord = 0;
    debugMode = 0; debugEntry = 0; curDualIssue = 0; threadStatus = 0;
    procNumPin = 0; bootOverwritePin = 0; core1OffPin = 0; oscTick = 0;
    skipOtpPollPin = 0; bootRamPin = 0; bootJtagPin = 0; bootPllModePin = 0;
    err_total = 0; checked = 0; cycles = 0;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    rdr(8'h02);
    chk("ctrlReset", 32'h0, rd);
    @(posedge clk_sys);
    #1;
    chk("psRdValidPulse", 32'h0, {31'h0, psRdValid});
    foreach (unmapped[i]) begin
      rdr(unmapped[i]);
      chk("unmapped", 32'h0, rd);
    end
    wr(8'h0C, 32'hFFFF_FFFF);
    rdr(8'h0C);
    chk("ramSize", psr_pkg::RAM_SIZE_BYTES & 32'hFFFF_FFFC, rd);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
      wr(8'h02, v);
      rdr(8'h02);
      chk("ctrl", v & ctlMask, rd);
      chk("txDataDelay", {24'h0, v[25:18]}, {24'h0, txDataDelay});
      chk("ctrlOuts", {29'h0, v[8], v[2], v[1]},
        {29'h0, rgmiiEnable, utmiSelect, ulpiEnable});
    end
    @(posedge clk_sys);
    clkEn <= 1'b0;
    wr(8'h02, 32'h0);
    clkEn <= 1'b1;
    rdr(8'h02);
    chk("clkEnLow", v & ctlMask, rd);
    for (int i = 0; i < 8; i++) begin
      wr(8'h02, {26'h0, i[1], i[0], 4'h0});
      allThreadsPaused <= i[2];
      @(posedge clk_sys);
      #1;
      chk("lpDivActive", {31'h0, i[0] & (~i[1] | i[2])},
        {31'h0, lpDivActive});
    end
    foreach (unmapped[i]) begin
      n = (i == 0) ? 0 : (i == 1) ? 4 : 7;
      if (i < 3) begin
        wr(8'h02, 32'(n) << 9);
        repeat (600) @(posedge clk_sys);
        h = 0;
        // ten whole periods, so the phase at the start does not matter
        repeat (10 * (n + 1)) begin
          @(posedge clk_sys);
          #1;
          if (txClk === 1'b1) h++;
        end
        chk("txClkHigh", 32'(10 * ((n >> 1) + 1)), 32'(h));
      end
    end
    for (int i = 0; i < 3; i++) begin
      v = $random(seed);
      {procNumPin, bootOverwritePin, core1OffPin, skipOtpPollPin} <= v[10:0];
      {bootRamPin, bootJtagPin, bootPllModePin} <= v[14:11];
      wr(8'h03, $random(seed));
      repeat (3) @(posedge clk_sys);
      rdr(8'h03);
      chk("bootStatus", bootExp(), rd);
    end
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 32'h7FFF_FFFF : ($random(seed) & 32'h7FFF_FFFF);
      wr(8'h05, v);
      rdr(8'h05);
      chk("secCfg", v & 32'h8000_5FB1, rd);
      chk("secOuts", secExp(v), secOut());
    end
    w = $random(seed) | 32'h8000_0000;
    wr(8'h05, w);
    wr(8'h05, ~w);
    rdr(8'h05);
    chk("secLocked", w & 32'h8000_5FB1, rd);
    v = $random(seed);
    @(posedge clk_sys);
    otpSecLoad <= 1'b1;
    otpSecWord <= v;
    @(posedge clk_sys);
    otpSecLoad <= 1'b0;
    rdr(8'h05);
    chk("secOtpLoad", v & 32'h8000_5FB1, rd);
    chk("secOtpOuts", secExp(v), secOut());
    curDualIssue <= 1'b1;
    wr(8'h10, 32'hFFFF_FFFF);
    rdr(8'h10);
    chk("ssrNoDebug", ssrExp(32'h0), rd);
    for (int i = 0; i < 4; i++) begin
      debugMode <= 1'b1;
      curDualIssue <= i[0];
      v = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
      wr(8'h10, v);
      rdr(8'h10);
      chk("ssrWrite", ssrExp(v), rd);
      w = $random(seed);
      @(posedge clk_sys);
      threadStatus <= w[10:0];
      debugEntry <= 1'b1;
      psWrite <= 1'b1;
      psRegNum <= 8'h10;
      psWdata <= ~w;
      @(posedge clk_sys);
      debugEntry <= 1'b0;
      psWrite <= 1'b0;
      rdr(8'h10);
      chk("ssrEntry", ssrExp({21'h0, w[10:0]}), rd);
    end
    for (int m = 3; m > 0; m--) begin
      readOsc(a);
      n = ($random(seed) & 7) + 1;
      wr(8'h06, 32'(m));
      rdr(8'h06);
      chk("oscCtrl", 32'(m), rd);
      chk("oscEnables", 32'(m), {30'h0, coreOscEnable, periphOscEnable});
      tick(n);
      wr(8'h06, 32'h0);
      repeat (12) @(posedge clk_sys);
      readOsc(b);
      for (int i = 0; i < 4; i++)
        chk("oscDelta", (i < 2 ? m >> 1 : m & 1) ? 32'(n) : 32'h0,
          (b[i] - a[i]) & 32'hFFFF);
    end
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    readOsc(a);
    for (int i = 0; i < 4; i++)
      chk("oscAfterReset", b[i], a[i]);
    rdr(8'h06);
    chk("oscCtrlReset", 32'h0, rd);
    final_report;
  end
endmodule : test_processor_status_regs
`default_nettype wire
